//--- design/gpp_map.svh
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// Register byte offsets
`define GPP_OFF_DATA_TOP 12'h3FC
`define GPP_OFF_DIR      12'h400
`define GPP_OFF_IS       12'h404
`define GPP_OFF_IBE      12'h408
`define GPP_OFF_IEV      12'h40C
`define GPP_OFF_IM       12'h410
`define GPP_OFF_RIS      12'h414
`define GPP_OFF_MIS      12'h418
`define GPP_OFF_ICR      12'h41C
`define GPP_OFF_FSEL     12'h420
`define GPP_OFF_DR2      12'h500
`define GPP_OFF_DR4      12'h504
`define GPP_OFF_DR8      12'h508
`define GPP_OFF_ODE      12'h50C
`define GPP_OFF_PUE      12'h510
`define GPP_OFF_PDE      12'h514
`define GPP_OFF_SLEW     12'h518
`define GPP_OFF_DIG      12'h51C
`define GPP_OFF_KEY      12'h520
`define GPP_OFF_COMMIT   12'h524

// Data window mask field
`define GPP_MASK_LSB     2
`define GPP_MASK_MSB     9

// Reset values and debug pin layouts
`define GPP_RST_ZERO     8'h00
`define GPP_RST_ALL      8'hFF
`define GPP_DBG_NONE     8'h00
`define GPP_DBG_ONE      8'h80
`define GPP_DBG_FOUR     8'h0F

// Unlock key, value arbitrary
`define GPP_UNLOCK_KEY   32'hC0DE_0001

`endif

//--- design/gpp_pkg.sv
package gpp_pkg;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpp_drive_t;

  typedef struct packed {
    logic [7:0] pull_up_enable;
    logic [7:0] pull_down_enable;
    logic [7:0] digital_enable;
    logic [7:0] drive_2ma_select;
    logic [7:0] drive_4ma_select;
    logic [7:0] drive_8ma_select;
    logic [7:0] slew_rate_limit;
  } gpp_padcfg_t;

  typedef enum logic [1:0] {
    GPP_IDLE   = 2'b00,
    GPP_ACCESS = 2'b01
  } gpp_apb_st_t;

endpackage : gpp_pkg

//--- design/gpp_sync.sv
module gpp_sync (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Raw and filtered levels
  input  wire logic [7:0] raw_in,
  output logic      [7:0] clean_q
);

  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;

  // Three stages; a change counts once stages two and three agree
  for (genvar i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[i]    <= 1'b0;
        s2_q[i]    <= 1'b0;
        s3_q[i]    <= 1'b0;
        clean_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= raw_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : gpp_sync

//--- design/gpp_port.sv
// Implementation choices: the address map and the APB register port.
`include "gpp_map.svh"

// What this block does
// - Ordinary pins reset undriven, select, enable and pulls all zero.
// - Select 0, output 0, open-drain 0, enable 1 gives a plain input.
// - Peripheral select with enable hands pin to peripheral; open-drain.
// - Sense edge/level, both edges, polarity high/rising, mask passes.
// - Unconnected bits ignore writes and read as nothing meaningful.
// - Select, pull-up, enable reset to debug function on debug pins.
// - Commit bits writable only on the debug pins, read-only elsewhere.
// - Commit resets to all ones except the debug pins.
// - Output select 0 captures the pin, 1 drives the data bit out.
// - Address bits 9 to 2 mask data register writes and reads.
// - Protected select bits store only when unlocked and committed.
// - Writing one to interrupt_clear clears a latched interrupt.
module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [7:0] DEBUG_PINS = `GPP_DBG_NONE,
  parameter logic [7:0] CONNECTED  = `GPP_RST_ALL
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pads
  input  wire logic [7:0]  pad_in,
  output gpp_drive_t       pad_drv,
  output gpp_padcfg_t      pad_cfg,
  // Peripheral side
  input  wire gpp_drive_t  periph_drv,
  output logic      [7:0]  periph_in,
  // Interrupt
  output logic             irq
);

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [7:0] upd(input logic [7:0] old,
                                     input logic       sel,
                                     input logic [7:0] wd);
    upd = sel ? ((wd & CONNECTED) | (old & ~CONNECTED)) : old;
  endfunction : upd

  gpp_apb_st_t st_q;
  gpp_apb_st_t st_d;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [7:0]  data_q;
  logic [7:0]  dir_q;
  logic [7:0]  is_q;
  logic [7:0]  ibe_q;
  logic [7:0]  iev_q;
  logic [7:0]  im_q;
  logic [7:0]  ris_q;
  logic [7:0]  fsel_q;
  logic [7:0]  dr2_q;
  logic [7:0]  dr4_q;
  logic [7:0]  dr8_q;
  logic [7:0]  ode_q;
  logic [7:0]  pue_q;
  logic [7:0]  pde_q;
  logic [7:0]  slew_q;
  logic [7:0]  dig_q;
  logic [7:0]  cr_q;
  logic        unlocked_q;
  logic [7:0]  prev_q;
  gpp_drive_t  pad_q;
  gpp_padcfg_t cfg_q;
  logic [7:0]  pin_in_q;
  logic        irq_q;

  logic [7:0]  sync_in;
  logic [7:0]  lvl;
  logic [7:0]  rd8;
  logic [31:0] rd;
  logic        unmapped;

  gpp_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (pad_in),
    .clean_q (sync_in)
  );

  // APB handshake: one access cycle, answer always ready
  wire setup = psel & ~penable & (st_q == GPP_IDLE);
  wire wr    = (st_q == GPP_ACCESS) & psel & penable & pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire in_data = (paddr[11:10] == 2'b00);
  wire [7:0] amask = paddr[`GPP_MASK_MSB:`GPP_MASK_LSB];

  wire w_data   = wr & in_data;
  wire w_dir    = wr & hit(paddr, `GPP_OFF_DIR);
  wire w_is     = wr & hit(paddr, `GPP_OFF_IS);
  wire w_ibe    = wr & hit(paddr, `GPP_OFF_IBE);
  wire w_iev    = wr & hit(paddr, `GPP_OFF_IEV);
  wire w_im     = wr & hit(paddr, `GPP_OFF_IM);
  wire w_icr    = wr & hit(paddr, `GPP_OFF_ICR);
  wire w_fsel   = wr & hit(paddr, `GPP_OFF_FSEL);
  wire w_dr2    = wr & hit(paddr, `GPP_OFF_DR2);
  wire w_dr4    = wr & hit(paddr, `GPP_OFF_DR4);
  wire w_dr8    = wr & hit(paddr, `GPP_OFF_DR8);
  wire w_ode    = wr & hit(paddr, `GPP_OFF_ODE);
  wire w_pue    = wr & hit(paddr, `GPP_OFF_PUE);
  wire w_pde    = wr & hit(paddr, `GPP_OFF_PDE);
  wire w_slew   = wr & hit(paddr, `GPP_OFF_SLEW);
  wire w_dig    = wr & hit(paddr, `GPP_OFF_DIG);
  wire w_key    = wr & hit(paddr, `GPP_OFF_KEY);
  wire w_commit = wr & hit(paddr, `GPP_OFF_COMMIT);

  // Masked data write, unconnected bits untouched
  wire [7:0] dmask  = amask & CONNECTED;
  wire [7:0] data_d = w_data ? ((wd & dmask) | (data_q & ~dmask))
                             : data_q;

  // Protected select bits need unlock plus commit
  wire [7:0] af_ok  = ~DEBUG_PINS | (cr_q & {8{unlocked_q}});
  wire [7:0] af_en  = af_ok & CONNECTED;
  wire [7:0] fsel_d = w_fsel ? ((wd & af_en) | (fsel_q & ~af_en))
                             : fsel_q;

  // Commit bits change only on debug pins while unlocked
  wire [7:0] cr_en = DEBUG_PINS & CONNECTED & {8{unlocked_q}};
  wire [7:0] cr_d  = w_commit ? ((wd & cr_en) | (cr_q & ~cr_en))
                              : cr_q;

  wire unlocked_d = w_key ? (pwdata == `GPP_UNLOCK_KEY) : unlocked_q;

  // Interrupt detection on the enabled input level
  assign lvl = sync_in & dig_q;
  wire [7:0] rise     = lvl & ~prev_q;
  wire [7:0] fall     = ~lvl & prev_q;
  wire [7:0] edge_hit = (ibe_q & (rise | fall)) |
                        (~ibe_q & iev_q & rise) |
                        (~ibe_q & ~iev_q & fall);
  wire [7:0] lvl_hit  = (iev_q & lvl) | (~iev_q & ~lvl);
  wire [7:0] event_v  = ((is_q & lvl_hit) | (~is_q & edge_hit))
                        & CONNECTED;
  wire [7:0] icr_clr  = w_icr ? wd : 8'h00;
  wire [7:0] ris_d    = (ris_q & ~icr_clr) | event_v;
  wire [7:0] mis      = ris_q & im_q;

  // Pad drive: peripheral, open-drain, push-pull, input or undriven
  wire [7:0] g_out  = data_q;
  wire [7:0] g_oe   = dir_q;
  wire [7:0] src_o  = (fsel_q & periph_drv.out) | (~fsel_q & g_out);
  wire [7:0] src_oe = (fsel_q & periph_drv.oe) | (~fsel_q & g_oe);
  wire [7:0] act    = src_oe & dig_q;
  gpp_drive_t pad_d;
  assign pad_d.out = src_o & ~ode_q;
  assign pad_d.oe  = act & ~(ode_q & src_o);

  // Strength and slew only matter while the pin can drive
  wire [7:0] drv_ok = (fsel_q | dir_q) & dig_q;
  gpp_padcfg_t cfg_d;
  assign cfg_d.pull_up_enable   = pue_q;
  assign cfg_d.pull_down_enable = pde_q;
  assign cfg_d.digital_enable   = dig_q;
  assign cfg_d.drive_2ma_select = dr2_q & drv_ok;
  assign cfg_d.drive_4ma_select = dr4_q & drv_ok;
  assign cfg_d.drive_8ma_select = dr8_q & drv_ok;
  assign cfg_d.slew_rate_limit  = slew_q & drv_ok;

  // Read data: outputs show the register, inputs the pin
  wire [7:0] data_rd = ((dir_q & data_q) | (~dir_q & lvl)) & amask;

  // Read select; clear register reads zero
  assign rd8 =
    in_data                     ? (data_rd & CONNECTED) :
    hit(paddr, `GPP_OFF_DIR)    ? dir_q :
    hit(paddr, `GPP_OFF_IS)     ? is_q :
    hit(paddr, `GPP_OFF_IBE)    ? ibe_q :
    hit(paddr, `GPP_OFF_IEV)    ? iev_q :
    hit(paddr, `GPP_OFF_IM)     ? im_q :
    hit(paddr, `GPP_OFF_RIS)    ? ris_q :
    hit(paddr, `GPP_OFF_MIS)    ? mis :
    hit(paddr, `GPP_OFF_FSEL)   ? fsel_q :
    hit(paddr, `GPP_OFF_DR2)    ? dr2_q :
    hit(paddr, `GPP_OFF_DR4)    ? dr4_q :
    hit(paddr, `GPP_OFF_DR8)    ? dr8_q :
    hit(paddr, `GPP_OFF_ODE)    ? ode_q :
    hit(paddr, `GPP_OFF_PUE)    ? pue_q :
    hit(paddr, `GPP_OFF_PDE)    ? pde_q :
    hit(paddr, `GPP_OFF_SLEW)   ? slew_q :
    hit(paddr, `GPP_OFF_DIG)    ? dig_q :
    hit(paddr, `GPP_OFF_KEY)    ? {7'h00, ~unlocked_q} :
    hit(paddr, `GPP_OFF_COMMIT) ? cr_q : 8'h00;
  wire in_lo = (paddr >= `GPP_OFF_DIR) && (paddr <= `GPP_OFF_FSEL);
  wire in_hi = (paddr >= `GPP_OFF_DR2) && (paddr <= `GPP_OFF_COMMIT);
  assign unmapped = ~in_data & ~((in_lo | in_hi) & (paddr[1:0] == 2'b00));

  assign rd   = {24'h00_0000, rd8};
  assign st_d = setup ? GPP_ACCESS : GPP_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= GPP_IDLE;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      pready_q  <= setup;
      prdata_q  <= setup ? rd : 32'h0000_0000;
      pslverr_q <= setup & unmapped;
    end
  end

  // Configuration reset: debug pins come up in debug function
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q     <= `GPP_RST_ZERO;
      dir_q      <= `GPP_RST_ZERO;
      is_q       <= `GPP_RST_ZERO;
      ibe_q      <= `GPP_RST_ZERO;
      iev_q      <= `GPP_RST_ZERO;
      im_q       <= `GPP_RST_ZERO;
      ris_q      <= `GPP_RST_ZERO;
      fsel_q     <= DEBUG_PINS;
      pue_q      <= DEBUG_PINS;
      dig_q      <= DEBUG_PINS;
      pde_q      <= `GPP_RST_ZERO;
      dr2_q      <= `GPP_RST_ZERO;
      dr4_q      <= `GPP_RST_ZERO;
      dr8_q      <= `GPP_RST_ZERO;
      ode_q      <= `GPP_RST_ZERO;
      slew_q     <= `GPP_RST_ZERO;
      cr_q       <= ~DEBUG_PINS;
      unlocked_q <= 1'b0;
    end else begin
      data_q     <= data_d;
      dir_q      <= upd(dir_q, w_dir, wd);
      is_q       <= upd(is_q, w_is, wd);
      ibe_q      <= upd(ibe_q, w_ibe, wd);
      iev_q      <= upd(iev_q, w_iev, wd);
      im_q       <= upd(im_q, w_im, wd);
      ris_q      <= ris_d;
      fsel_q     <= fsel_d;
      pue_q      <= upd(pue_q, w_pue, wd);
      dig_q      <= upd(dig_q, w_dig, wd);
      pde_q      <= upd(pde_q, w_pde, wd);
      dr2_q      <= upd(dr2_q, w_dr2, wd);
      dr4_q      <= upd(dr4_q, w_dr4, wd);
      dr8_q      <= upd(dr8_q, w_dr8, wd);
      ode_q      <= upd(ode_q, w_ode, wd);
      slew_q     <= upd(slew_q, w_slew, wd);
      cr_q       <= cr_d;
      unlocked_q <= unlocked_d;
    end
  end

  // Registered pad, peripheral and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q   <= 8'h00;
      pad_q    <= '0;
      cfg_q    <= '0;
      pin_in_q <= 8'h00;
      irq_q    <= 1'b0;
    end else begin
      prev_q   <= lvl;
      pad_q    <= pad_d;
      cfg_q    <= cfg_d;
      pin_in_q <= lvl;
      irq_q    <= |mis;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign pad_drv   = pad_q;
  assign pad_cfg   = cfg_q;
  assign periph_in = pin_in_q;
  assign irq       = irq_q;

  property p_undriven;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((pad_q.oe & ~$past(dig_q)) == 8'h00);
  endproperty
  a_undriven: assert property (p_undriven)
    else $error("Pin driven while digital enable is clear");

  property p_input_mode;
    @(posedge pclk) disable iff (!presetn)
      ((~fsel_q & ~dir_q & ~ode_q & dig_q) != 8'h00) |=>
        ((pad_q.oe & $past(~fsel_q & ~dir_q)) == 8'h00);
  endproperty
  a_input_mode: assert property (p_input_mode)
    else $error("Input pin is being driven");

  property p_periph;
    @(posedge pclk) disable iff (!presetn)
      (fsel_q[4] & dig_q[4] & ~ode_q[4]) |=>
        (pad_q.out[4] == $past(periph_drv.out[4]) &&
         pad_q.oe[4] == $past(periph_drv.oe[4]));
  endproperty
  a_periph: assert property (p_periph)
    else $error("Pin 4 not following its peripheral");

  property p_rise_irq;
    @(posedge pclk) disable iff (!presetn)
      (rise[6] & ~is_q[6] & ~ibe_q[6] & iev_q[6] & CONNECTED[6])
        |=> ris_q[6] ##1 (irq || !$past(im_q[6]));
  endproperty
  a_rise_irq: assert property (p_rise_irq)
    else $error("Rising edge did not latch pin 6");

  property p_both;
    @(posedge pclk) disable iff (!presetn)
      (fall[6] & ~is_q[6] & ibe_q[6] & CONNECTED[6]) |=> ris_q[6];
  endproperty
  a_both: assert property (p_both)
    else $error("Both-edge pin missed a falling edge");

  property p_unconn;
    @(posedge pclk) disable iff (!presetn)
      ((dir_q | im_q | ode_q) & ~CONNECTED) == 8'h00;
  endproperty
  a_unconn: assert property (p_unconn)
    else $error("Unconnected bit took a write");

  property p_mask_read;
    @(posedge pclk) disable iff (!presetn)
      (setup & in_data & ~pwrite) |=>
        ((prdata[7:0] & ~$past(amask)) == 8'h00) && pready;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("Masked-off data bit read as one");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      (w_fsel & ~unlocked_q) |=>
        ((fsel_q & DEBUG_PINS) == $past(fsel_q & DEBUG_PINS));
  endproperty
  a_protect: assert property (p_protect)
    else $error("Locked select bit changed");

  property p_commit_ro;
    @(posedge pclk) disable iff (!presetn)
      ((cr_q & ~DEBUG_PINS) == ~DEBUG_PINS);
  endproperty
  a_commit_ro: assert property (p_commit_ro)
    else $error("Commit bit of ordinary pin changed");

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (w_icr & wd[6] & ~event_v[6]) |=>
        !ris_q[6] ##1 !(irq && ($past(im_q) == 8'h40));
  endproperty
  a_clear: assert property (p_clear)
    else $error("Interrupt clear did not take effect");

endmodule : gpp_port

//--- tb/gpp_pins.sv
module gpp_pins
  import gpp_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Device side
  input  wire gpp_drive_t  pad_drv,
  input  wire gpp_padcfg_t pad_cfg,
  // Board side
  input  wire logic [7:0]  ext_val,
  input  wire logic [7:0]  ext_oe,
  output logic      [7:0]  pad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] float_q = 8'h55;

  // Undriven pads toggle every clock, so the input filter holds the last stable level
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // Pad level: device driver, then board driver, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_drv.oe[i])
        pad_in[i] = pad_drv.out[i];
      else if (ext_oe[i])
        pad_in[i] = ext_val[i];
      else if (pad_cfg.pull_up_enable[i])
        pad_in[i] = 1'b1;
      else if (pad_cfg.pull_down_enable[i])
        pad_in[i] = 1'b0;
      else
        pad_in[i] = float_q[i];
    end
  end
endmodule : gpp_pins

//--- tb/gpp_port_bench.sv
`include "gpp_map.svh"

module gpp_port_bench
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] DBG = `GPP_DBG_FOUR;
  localparam logic [7:0] CON = 8'h7F;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pad_in;
  logic [7:0]  periph_in;
  logic [7:0]  ext_val;
  logic [7:0]  ext_oe;
  gpp_drive_t  pad_drv;
  gpp_drive_t  periph_drv;
  gpp_padcfg_t pad_cfg;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch;
  int          check_count;
  int          cycles;

  gpp_port #(.DEBUG_PINS(DBG), .CONNECTED(CON)) gpp_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_drv(pad_drv), .pad_cfg(pad_cfg), .periph_drv(periph_drv),
    .periph_in(periph_in), .irq(irq)
  );

  gpp_pins gpp_pins_inst (
    .pclk(pclk), .pad_drv(pad_drv), .pad_cfg(pad_cfg),
    .ext_val(ext_val), .ext_oe(ext_oe), .pad_in(pad_in)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_n

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic is_wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic c8(input logic [7:0] got, input logic [7:0] exp);
    chk({24'h00_0000, got}, {24'h00_0000, exp});
  endtask : c8

  // Register read; unconnected bits are not compared
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk({rd[31:8], rd[7:0] & CON}, {24'h00_0000, e & CON});
  endtask : rchk

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0000_0000;
    ext_val    = 8'h40;
    ext_oe     = 8'h40;
    periph_drv = '0;
    wait_n(10);
    c8(pad_drv.oe, 8'h00);
    c8(pad_cfg.pull_down_enable, 8'h00);
    presetn <= 1'b1;
    wait_n(3);
    c8(pad_cfg.digital_enable & CON, DBG);
    c8(pad_cfg.pull_up_enable & CON, DBG);
    rchk(`GPP_OFF_FSEL, DBG);
    rchk(`GPP_OFF_PUE, DBG);
    rchk(`GPP_OFF_DIG, DBG);
    rchk(`GPP_OFF_COMMIT, ~DBG);
    rchk(`GPP_OFF_PDE, 8'h00);
    // Protection while locked, then writes after unlock and commit
    wr(`GPP_OFF_COMMIT, 32'h0000_0000);
    rchk(`GPP_OFF_COMMIT, ~DBG);
    wr(`GPP_OFF_FSEL, 32'h0000_0030);
    rchk(`GPP_OFF_FSEL, 8'h3F);
    rchk(`GPP_OFF_KEY, 8'h01);
    wr(`GPP_OFF_KEY, `GPP_UNLOCK_KEY);
    rchk(`GPP_OFF_KEY, 8'h00);
    wr(`GPP_OFF_COMMIT, 32'h0000_000F);
    rchk(`GPP_OFF_COMMIT, 8'hFF);
    wr(`GPP_OFF_FSEL, 32'h0000_0030);
    rchk(`GPP_OFF_FSEL, 8'h30);
    wr(`GPP_OFF_KEY, 32'h0000_0000);
    rchk(`GPP_OFF_KEY, 8'h01);
    // Outputs on 3:0, peripheral on 5:4, input on 6
    wr(`GPP_OFF_DIR, 32'h0000_00BF);
    wr(`GPP_OFF_DIG, 32'h0000_00FF);
    wr(`GPP_OFF_DATA_TOP, 32'h0000_00FF);
    wait_n(2);
    c8(pad_drv.oe, 8'h0F);
    c8(pad_drv.out & 8'h0F, 8'h0F);
    wr(12'h004, 32'h0000_0000);
    wait_n(2);
    c8(pad_drv.out & 8'h0F, 8'h0E);
    wait_n(6);
    rchk(12'h13C, 8'h4E);
    c8(periph_in & 8'h40, 8'h40);
    wr(`GPP_OFF_DR8, 32'h0000_00FF);
    wait_n(2);
    c8(pad_cfg.drive_8ma_select & CON, 8'h3F);
    periph_drv <= '{out: 8'h10, oe: 8'h30};
    wait_n(3);
    c8(pad_drv.oe & 8'h30, 8'h30);
    c8(pad_drv.out & 8'h30, 8'h10);
    wr(`GPP_OFF_ODE, 32'h0000_0020);
    wait_n(2);
    c8(pad_drv.oe & 8'h30, 8'h30);
    periph_drv <= '{out: 8'h30, oe: 8'h30};
    wait_n(3);
    c8(pad_drv.oe & 8'h30, 8'h10);
    // Single rising edge on pin 6
    wr(`GPP_OFF_IEV, 32'h0000_0040);
    wr(`GPP_OFF_IM, 32'h0000_0040);
    wr(`GPP_OFF_ICR, 32'h0000_00FF);
    ext_val <= 8'h00;
    wait_n(10);
    chk(irq, 1'b0);
    ext_val <= 8'h40;
    wait_n(10);
    chk(irq, 1'b1);
    rchk(`GPP_OFF_RIS, 8'h40);
    wait_n(10);
    chk(irq, 1'b1);
    wr(`GPP_OFF_ICR, 32'h0000_0040);
    wait_n(3);
    chk(irq, 1'b0);
    // Both edges, polarity cleared
    wr(`GPP_OFF_IEV, 32'h0000_0000);
    wr(`GPP_OFF_IBE, 32'h0000_0040);
    ext_val <= 8'h00;
    wait_n(10);
    chk(irq, 1'b1);
    wr(`GPP_OFF_ICR, 32'h0000_0040);
    wait_n(3);
    chk(irq, 1'b0);
    ext_val <= 8'h40;
    wait_n(10);
    chk(irq, 1'b1);
    // High level keeps re-latching over a clear
    wr(`GPP_OFF_IBE, 32'h0000_0000);
    wr(`GPP_OFF_IEV, 32'h0000_0040);
    wr(`GPP_OFF_IS, 32'h0000_0040);
    wr(`GPP_OFF_ICR, 32'h0000_0040);
    wait_n(3);
    chk(irq, 1'b1);
    rchk(`GPP_OFF_MIS, 8'h40);
    wr(`GPP_OFF_IM, 32'h0000_0000);
    wait_n(3);
    chk(irq, 1'b0);
    // Digital enable off isolates the input
    wr(`GPP_OFF_DIG, 32'h0000_00BF);
    wait_n(3);
    c8(periph_in & 8'h40, 8'h00);
    apb(1'b0, 12'h600, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    test_done();
  end
endmodule : gpp_port_bench
